// ### hw/ofs_fuse_seq.sv
// One-time fuse programming sequencer with Avalon-MM register access.
// Assumes fuse sense levels arrive asynchronously and prog_clk_i runs
// while prog_clk_en_o is high; the bus master honours waitrequest.
`timescale 1ns/1ps
module ofs_fuse_seq (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        prog_clk_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [7:0]  fuse_sense_i,
  output logic      [7:0]  fuse_blow_o,
  output logic             prog_clk_en_o,
  input  wire logic        slave_address_select_pin_i,
  output logic      [6:0]  i2c_address_o,
  output logic      [63:0] tap_select_o
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [5:0]  wiper;
    logic        busy;
    logic [1:0]  status;
    logic        start_tgl;
    logic        done_seen;
    logic [1:0]  load_cnt;
    logic [6:0]  addr;
  } ofs_bus_t;

  typedef struct packed {
    ofs_pkg::ofs_state_t st;
    logic [7:0]          blow;
    logic [2:0]          idx;
    logic [1:0]          wait_cnt;
    logic [5:0]          code;
    logic [1:0]          result;
    logic                done_tgl;
    logic                start_seen;
  } ofs_prog_t;

  ofs_bus_t  b_q;
  ofs_bus_t  b_d;
  ofs_prog_t p_q;
  ofs_prog_t p_d;

  logic [9:0] bus_sync;
  logic [7:0] sense_b;
  logic       done_b;
  logic       pin_b;
  logic [8:0] prog_sync;
  logic [7:0] sense_p;
  logic       start_p;
  logic       prog_rst_n;
  logic       req;
  logic       lock_now;
  logic       trig_ok;
  logic       wr_ctrl;

  function automatic logic is_reg(input logic [3:0] a,
                                  input logic [3:0] off);
    is_reg = (a == off);
  endfunction : is_reg

  // Synchronisers into the bus domain
  ofs_sync #(.W(10)) u_sync_bus (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({slave_address_select_pin_i, p_q.done_tgl, fuse_sense_i}),
    .q_o       (bus_sync)
  );
  assign sense_b = bus_sync[7:0];
  assign done_b  = bus_sync[8];
  assign pin_b   = bus_sync[9];

  // Reset into the programming domain; only a constant feeds its own reset
  ofs_sync #(.W(1)) u_sync_rst (
    .clk_i     (prog_clk_i),
    .reset_n_i (1'b1),
    .d_i       (reset_n_i),
    .q_o       (prog_rst_n)
  );

  ofs_sync #(.W(9)) u_sync_prog (
    .clk_i     (prog_clk_i),
    .reset_n_i (prog_rst_n),
    .d_i       ({b_q.start_tgl, fuse_sense_i}),
    .q_o       (prog_sync)
  );
  assign sense_p = prog_sync[7:0];
  assign start_p = prog_sync[8];

  ofs_tap_dec u_tap (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .code_i    (b_q.wiper),
    .tap_o     (tap_select_o)
  );

  // Requests wait out the power-on fuse load
  assign req      = (avs_read_i | avs_write_i) & (b_q.load_cnt == 2'h0);
  assign lock_now = (b_q.status == ofs_pkg::OFS_ST_LOCKED);
  // Writes land at the accept edge, where waitrequest is seen low
  assign wr_ctrl  = req & avs_write_i & b_q.ack & avs_byteenable_i[0]
                    & is_reg(avs_address_i, ofs_pkg::OFS_CTRL_OFF);
  // Only a ready, idle part may start; terminal states stay terminal
  assign trig_ok  = wr_ctrl & avs_byteenable_i[1]
                    & avs_writedata_i[ofs_pkg::OFS_CTRL_TRIG_BIT]
                    & ~b_q.busy & (b_q.status == ofs_pkg::OFS_ST_READY);

  always_comb
  begin
    b_d       = b_q;
    b_d.ack   = req & ~b_q.ack;
    b_d.addr  = {ofs_pkg::OFS_ADDR_BASE[6:1], pin_b};
    if (b_q.load_cnt != 2'h0)
    begin
      b_d.load_cnt = b_q.load_cnt - 2'h1;
      if (b_q.load_cnt == 2'h1 && sense_b[ofs_pkg::OFS_FUSE_LOCK_BIT])
      begin
        b_d.wiper  = sense_b[5:0];
        b_d.status = ofs_pkg::OFS_ST_LOCKED;
      end
    end
    if (req & avs_read_i & ~b_q.ack)
    begin
      b_d.rdata = 32'h0000_0000;
      if (is_reg(avs_address_i, ofs_pkg::OFS_CTRL_OFF))
        b_d.rdata[5:0] = b_q.wiper;
      else if (is_reg(avs_address_i, ofs_pkg::OFS_STATUS_OFF))
      begin
        b_d.rdata[1:0] = b_q.status;
        b_d.rdata[ofs_pkg::OFS_STAT_BUSY_BIT] = b_q.busy;
        b_d.rdata[ofs_pkg::OFS_STAT_LOCK_BIT] = lock_now;
      end
      else if (is_reg(avs_address_i, ofs_pkg::OFS_FUSE_OFF))
        b_d.rdata[7:0] = sense_b;
    end
    // Code frozen while busy and after locking
    if (wr_ctrl & ~b_q.busy & ~lock_now)
      b_d.wiper = avs_writedata_i[5:0];
    if (trig_ok)
    begin
      b_d.busy      = 1'b1;
      b_d.start_tgl = ~b_q.start_tgl;
    end
    // Result is stable once the done toggle has crossed
    if (done_b != b_q.done_seen)
    begin
      b_d.done_seen = done_b;
      b_d.busy      = 1'b0;
      b_d.status    = p_q.result;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      b_q          <= '0;
      b_q.wiper    <= ofs_pkg::OFS_MIDSCALE;
      b_q.status   <= ofs_pkg::OFS_ST_READY;
      b_q.load_cnt <= ofs_pkg::OFS_LOAD_WAIT;
      b_q.addr     <= ofs_pkg::OFS_ADDR_BASE;
    end
    else
      b_q <= b_d;
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~b_q.ack;
  assign avs_readdata_o    = b_q.rdata;
  assign i2c_address_o     = b_q.addr;
  assign prog_clk_en_o     = b_q.busy;
  assign fuse_blow_o       = p_q.blow;

  // Programming domain; the code is read only after the start toggle,
  // when the bus side holds it still
  always_comb
  begin
    p_d      = p_q;
    p_d.blow = 8'h00;
    case (p_q.st)
      ofs_pkg::OFS_IDLE:
        if (start_p != p_q.start_seen)
        begin
          p_d.start_seen = start_p;
          p_d.code       = b_q.wiper;
          p_d.st         = ofs_pkg::OFS_TEST_BLOW;
        end
      ofs_pkg::OFS_TEST_BLOW:
      begin
        p_d.blow[ofs_pkg::OFS_FUSE_TEST_BIT] = 1'b1;
        p_d.wait_cnt = ofs_pkg::OFS_SETTLE;
        p_d.st       = ofs_pkg::OFS_TEST_CHECK;
      end
      ofs_pkg::OFS_TEST_CHECK:
        if (p_q.wait_cnt != 2'h0)
          p_d.wait_cnt = p_q.wait_cnt - 2'h1;
        else if (sense_p[ofs_pkg::OFS_FUSE_TEST_BIT])
        begin
          p_d.idx = 3'h0;
          p_d.st  = ofs_pkg::OFS_DATA;
        end
        else
        begin
          p_d.result   = ofs_pkg::OFS_ST_TFAIL;
          p_d.done_tgl = ~p_q.done_tgl;
          p_d.st       = ofs_pkg::OFS_IDLE;
        end
      ofs_pkg::OFS_DATA:
      begin
        // Only fuses whose code bit is one are blown
        p_d.blow[p_q.idx] = p_q.code[p_q.idx];
        p_d.idx = p_q.idx + 3'h1;
        if (p_q.idx == ofs_pkg::OFS_DATA_LAST)
        begin
          p_d.wait_cnt = ofs_pkg::OFS_SETTLE;
          p_d.st       = ofs_pkg::OFS_COMPARE;
        end
      end
      ofs_pkg::OFS_COMPARE:
        if (p_q.wait_cnt != 2'h0)
          p_d.wait_cnt = p_q.wait_cnt - 2'h1;
        else if (sense_p[5:0] == p_q.code)
          p_d.st = ofs_pkg::OFS_LOCK_BLOW;
        else
        begin
          p_d.result   = ofs_pkg::OFS_ST_FATAL;
          p_d.done_tgl = ~p_q.done_tgl;
          p_d.st       = ofs_pkg::OFS_IDLE;
        end
      ofs_pkg::OFS_LOCK_BLOW:
      begin
        p_d.blow[ofs_pkg::OFS_FUSE_LOCK_BIT] = 1'b1;
        p_d.result   = ofs_pkg::OFS_ST_LOCKED;
        p_d.done_tgl = ~p_q.done_tgl;
        p_d.st       = ofs_pkg::OFS_IDLE;
      end
      default:
        p_d.st = ofs_pkg::OFS_IDLE;
    endcase
  end

  always_ff @(posedge prog_clk_i)
  begin
    if (!prog_rst_n)
    begin
      p_q    <= '0;
      p_q.st <= ofs_pkg::OFS_IDLE;
    end
    else
      p_q <= p_d;
  end

  // Checks in the bus domain
  sequence s_trig;
    trig_ok;
  endsequence

  sequence s_six_data;
    (p_q.st == ofs_pkg::OFS_DATA) [*6];
  endsequence

  trig_busy_a : assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    s_trig |=> b_q.busy && prog_clk_en_o)
    else $error("accepted trigger did not raise busy");

  frozen_wiper_a : assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (b_q.busy && !(done_b != b_q.done_seen)) |=> $stable(b_q.wiper))
    else $error("wiper changed during the fuse sequence");

  mid_load_a : assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (b_q.load_cnt == 2'h1 && !sense_b[ofs_pkg::OFS_FUSE_LOCK_BIT])
    |=> b_q.wiper == ofs_pkg::OFS_MIDSCALE)
    else $error("unprogrammed part did not load midscale");

  lock_refuse_a : assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (lock_now && !b_q.busy) |=> !b_q.busy && lock_now)
    else $error("locked part started programming");

  status_read_a : assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (req && avs_read_i && !b_q.ack
     && avs_address_i == ofs_pkg::OFS_STATUS_OFF)
    |=> avs_readdata_o[1:0] == $past(b_q.status) && !avs_waitrequest_o)
    else $error("status read returned wrong validation bits");

  tap_follow_a : assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ##1 tap_select_o == (64'h1 << $past(b_q.wiper)))
    else $error("tap select does not follow the wiper code");

  // Checks in the programming domain
  test_fail_a : assert property (
    @(posedge prog_clk_i) disable iff (!prog_rst_n)
    (p_q.st == ofs_pkg::OFS_TEST_CHECK && p_q.wait_cnt == 2'h0
     && !sense_p[ofs_pkg::OFS_FUSE_TEST_BIT])
    |=> p_q.result == ofs_pkg::OFS_ST_TFAIL && p_q.st == ofs_pkg::OFS_IDLE)
    else $error("test fuse failure not reported as 01");

  data_six_a : assert property (
    @(posedge prog_clk_i) disable iff (!prog_rst_n)
    $rose(p_q.st == ofs_pkg::OFS_DATA)
    |-> s_six_data ##1 p_q.st == ofs_pkg::OFS_COMPARE)
    else $error("data fuses not programmed in six cycles");

  mismatch_a : assert property (
    @(posedge prog_clk_i) disable iff (!prog_rst_n)
    (p_q.st == ofs_pkg::OFS_COMPARE && p_q.wait_cnt == 2'h0
     && sense_p[5:0] != p_q.code)
    |=> p_q.result == ofs_pkg::OFS_ST_FATAL && fuse_blow_o == 8'h00)
    else $error("data fuse mismatch not reported as 10");

  match_lock_a : assert property (
    @(posedge prog_clk_i) disable iff (!prog_rst_n)
    (p_q.st == ofs_pkg::OFS_COMPARE && p_q.wait_cnt == 2'h0
     && sense_p[5:0] == p_q.code)
    |=> ##1 fuse_blow_o == 8'h80 && p_q.result == ofs_pkg::OFS_ST_LOCKED)
    else $error("matching fuses did not blow the lock fuse");

endmodule : ofs_fuse_seq

// ### hw/ofs_pkg.sv
// Shared constants and types for the one-time fuse programming sequencer.
// Assumes a 32-bit Avalon-MM register bus and a separate programming clock.
package ofs_pkg;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL_OFF   = 4'h0;
  localparam logic [3:0] OFS_STATUS_OFF = 4'h4;
  localparam logic [3:0] OFS_FUSE_OFF   = 4'h8;

  // Field positions
  localparam int OFS_CTRL_TRIG_BIT  = 8;
  localparam int OFS_STAT_BUSY_BIT  = 2;
  localparam int OFS_STAT_LOCK_BIT  = 3;
  localparam int OFS_FUSE_TEST_BIT  = 6;
  localparam int OFS_FUSE_LOCK_BIT  = 7;

  // Widths and reset values
  localparam int         OFS_CODE_W    = 6;
  localparam int         OFS_FUSE_W    = 8;
  localparam int         OFS_TAP_N     = 64;
  localparam logic [5:0] OFS_MIDSCALE  = 6'h20;
  localparam logic [6:0] OFS_ADDR_BASE = 7'h2C; // Arbitrary value

  // Validation status codes
  localparam logic [1:0] OFS_ST_READY  = 2'h0;
  localparam logic [1:0] OFS_ST_TFAIL  = 2'h1;
  localparam logic [1:0] OFS_ST_FATAL  = 2'h2;
  localparam logic [1:0] OFS_ST_LOCKED = 2'h3;

  // Timing counts
  localparam logic [1:0] OFS_LOAD_WAIT = 2'h3; // Covers the sense synchroniser
  localparam logic [1:0] OFS_SETTLE    = 2'h3; // Fuse sense settle, prog clocks
  localparam logic [2:0] OFS_DATA_LAST = 3'h5;

  typedef enum logic [2:0] {
    OFS_IDLE,
    OFS_TEST_BLOW,
    OFS_TEST_CHECK,
    OFS_DATA,
    OFS_COMPARE,
    OFS_LOCK_BLOW
  } ofs_state_t;

endpackage : ofs_pkg

// ### hw/ofs_sync.sv
// Two flip-flop level synchroniser, any width.
// Assumes each bit is a level that stays put for several destination clocks.
`timescale 1ns/1ps
module ofs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ofs_sync_t;

  ofs_sync_t s_q;
  ofs_sync_t s_d;

  always_comb
  begin
    s_d.meta = d_i;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign q_o = s_q.sync;

endmodule : ofs_sync

// ### hw/ofs_tap_dec.sv
// Wiper code to one-hot tap select decoder, registered.
// Assumes the code comes from logic on the same clock.
`timescale 1ns/1ps
module ofs_tap_dec (
  input  wire logic                           clk_i,
  input  wire logic                           reset_n_i,
  input  wire logic [ofs_pkg::OFS_CODE_W-1:0] code_i,
  output logic      [ofs_pkg::OFS_TAP_N-1:0]  tap_o
);

  typedef struct packed {
    logic [ofs_pkg::OFS_TAP_N-1:0] tap;
  } ofs_tap_t;

  ofs_tap_t s_q;
  ofs_tap_t s_d;

  // Code zero is the B end; each step moves one tap toward A
  always_comb
  begin
    s_d.tap         = '0;
    s_d.tap[code_i] = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      s_q.tap <= 64'h1 << ofs_pkg::OFS_MIDSCALE;
    else
      s_q <= s_d;
  end

  assign tap_o = s_q.tap;

endmodule : ofs_tap_dec

// ### verif/ofs_fuse_arr.sv
// Behavioural fuse array at the far side of the fuse programming sequencer.
// Assumes blow pulses arrive on the programming clock; fuses persist across
// device resets and are cleared only when a fresh unit is swapped in.
`timescale 1ns/1ps
module ofs_fuse_arr (
  input  wire logic       prog_clk_i,
  input  wire logic       wipe_i,
  input  wire logic       fail_test_i,
  input  wire logic       fail_data_i,
  input  wire logic [7:0] blow_i,
  output logic      [7:0] sense_o
);
  logic [7:0] keep;

  // A weak fuse ignores its blow pulse, which the failure scenarios rely on
  assign keep = ~{1'b0, fail_test_i, 5'h00, fail_data_i};

  // Six data fuses, test fuse, lock fuse; state survives power-on
  always @(posedge prog_clk_i)
  begin
    if (wipe_i)
      sense_o <= 8'h00;
    else
      sense_o <= sense_o | (blow_i & keep);
  end
endmodule : ofs_fuse_arr

// ### verif/test_otp_fuse_program_sequencer.sv
// Self-checking bench for the fuse programming sequencer.
// Assumes the fuse array model above and a free-running programming clock.
`timescale 1ns/1ps
module test_otp_fuse_program_sequencer;
  typedef struct {logic [5:0] code; logic [63:0] tap;} ofs_row_t;
  logic        clk_i = 1'b0;
  logic        prog_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic        wreq;
  logic [7:0]  sense;
  logic [7:0]  blow;
  logic        clk_en;
  logic        pin = 1'b0;
  logic [3:0]  be = 4'hF;
  logic [6:0]  i2c_addr;
  logic [63:0] tap;
  logic        wipe = 1'b0;
  logic        f_test = 1'b0;
  logic        f_data = 1'b0;
  logic [31:0] r;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  ofs_row_t    rows [3] = '{'{6'h00, 64'h1},
                            '{6'h3F, 64'h8000_0000_0000_0000},
                            '{6'h15, 64'h20_0000}};

  always #2.5 clk_i = ~clk_i;
  initial #1.7 forever #6 prog_clk = ~prog_clk;

  ofs_fuse_seq i_ofs_fuse_seq (
    .clk_i(clk_i), .reset_n_i(reset_n), .prog_clk_i(prog_clk),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .fuse_sense_i(sense), .fuse_blow_o(blow), .prog_clk_en_o(clk_en),
    .slave_address_select_pin_i(pin), .i2c_address_o(i2c_addr),
    .tap_select_o(tap));

  ofs_fuse_arr i_ofs_fuse_arr (
    .prog_clk_i(prog_clk), .wipe_i(wipe), .fail_test_i(f_test),
    .fail_data_i(f_data), .blow_i(blow), .sense_o(sense));

  task automatic stop_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Request held until waitrequest is seen low, then released at that edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge clk_i);
    while (wreq !== 1'b0)
      @(posedge clk_i);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rst(input logic w);
    @(posedge clk_i);
    reset_n <= 1'b0;
    wipe <= w;
    repeat (20) @(posedge clk_i);
    reset_n <= 1'b1;
    wipe <= 1'b0;
  endtask : rst

  // Bounded wait for a full fuse sequence to start and finish
  task automatic run_wait;
    int n;
    n = 0;
    while (clk_en !== 1'b1 && n < 200)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(clk_en, 1'b1);
    while (clk_en !== 1'b0 && n < 2000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(clk_en, 1'b0);
    repeat (10) @(posedge clk_i);
  endtask : run_wait

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc >= 20000)
    begin
      n_errors++;
      stop_test();
    end
  end

  initial
  begin
    rst(1'b1);
    chk(tap, 64'h1_0000_0000);
    bus(1'b0, 4'h0, 32'h0, r);
    chk(r, 32'h20);
    bus(1'b0, 4'h4, 32'h0, r);
    chk(r, 32'h0);
    foreach (rows[i])
    begin
      bus(1'b1, 4'h0, {26'h0, rows[i].code}, r);
      bus(1'b0, 4'h0, 32'h0, r);
      chk(r, {26'h0, rows[i].code});
      repeat (3) @(posedge clk_i);
      chk(tap, rows[i].tap);
    end
    bus(1'b0, 4'hC, 32'h0, r);
    chk(r, 32'h0);
    chk(i2c_addr, {ofs_pkg::OFS_ADDR_BASE[6:1], 1'b0});
    pin <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk(i2c_addr, {ofs_pkg::OFS_ADDR_BASE[6:1], 1'b1});
    // Trigger without its upper byte enable must not start anything
    be <= 4'h1;
    bus(1'b1, 4'h0, 32'h12A, r);
    be <= 4'hF;
    repeat (20) @(posedge clk_i);
    chk(clk_en, 1'b0);
    bus(1'b0, 4'h4, 32'h0, r);
    chk(r, 32'h0);
    // Unit with a weak test fuse halts before any data fuse
    f_test <= 1'b1;
    bus(1'b1, 4'h0, 32'h12A, r);
    run_wait();
    bus(1'b0, 4'h4, 32'h0, r);
    chk(r, 32'h1);
    chk(sense, 8'h00);
    f_test <= 1'b0;
    // Fresh unit whose data fuse 0 will not blow
    rst(1'b1);
    f_data <= 1'b1;
    bus(1'b1, 4'h0, 32'h12B, r);
    run_wait();
    bus(1'b0, 4'h4, 32'h0, r);
    chk(r, 32'h2);
    chk(sense, 8'h6A);
    f_data <= 1'b0;
    // Failed unit is discarded; fresh unit, good fuses
    rst(1'b1);
    bus(1'b1, 4'h0, 32'h2D, r);
    bus(1'b1, 4'h0, 32'h115, r);
    @(negedge clk_i);
    chk(clk_en, 1'b1);
    bus(1'b1, 4'h0, 32'h03, r);
    run_wait();
    bus(1'b0, 4'h4, 32'h0, r);
    chk(r, 32'hB);
    bus(1'b0, 4'h8, 32'h0, r);
    chk(r, 32'hD5);
    bus(1'b1, 4'h0, 32'h10A, r);
    repeat (40) @(posedge clk_i);
    chk(clk_en, 1'b0);
    bus(1'b0, 4'h0, 32'h0, r);
    chk(r, 32'h15);
    // Power cycle of a locked unit loads the stored code
    rst(1'b0);
    bus(1'b0, 4'h0, 32'h0, r);
    chk(r, 32'h15);
    bus(1'b0, 4'h4, 32'h0, r);
    chk(r, 32'hB);
    repeat (3) @(posedge clk_i);
    chk(tap, 64'h20_0000);
    stop_test();
  end
endmodule : test_otp_fuse_program_sequencer
